//--- hw/vcf_capture.v
// Video capture front end: connector byte input, windowing, downscaling.
// Assumes the pixel clock and connector pins are asynchronous to clock and
// at most about a quarter of its rate, so edges are found by oversampling.
//
// Functional notes
// - Video registers stay locked until key value is written to key index.
// - While locked, video register reads and writes are refused.
// - Each received byte pair is joined into one RGB565 pixel word.
// - RGB565 video at the stated pixel rate is passed on pixel by pixel.
// - Interlaced and non-interlaced input are both accepted.
// - Standard mode drives graphics data out and still accepts video input.
// - Connector data pin direction follows the enable pin and standard mode bit.
// - Horizontal counter clears on blank rise, counts on each pixel clock.
// - Vertical counter clears on sync rise, counts on each blank rise.
// - Capture runs when both counts reach their start values.
// - Capture stops when either count reaches its end value.
// - Image is scaled down independently in X and Y by n/64 steps.
// - Scale fields 0 to 63 give factor of 64 minus field over 64.
// - Connector bytes are sampled only while data-valid is high.
// - Input accepted only while enable pin is low and capture is set.
`timescale 1ns/1ps
`include "vcf_consts.vh"

module vcf_capture #(
	parameter CNT_W      = 12,
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW    = 4
) (
	input  wire        clock,                     // System clock, 100 MHz
	input  wire        arst_n,                    // Async reset, active low
	input  wire        reg_cs,                    // Register port select
	input  wire        reg_addr,                  // 0 index port, 1 data port
	input  wire        reg_wr,                    // Write strobe
	input  wire        reg_rd,                    // Read strobe
	input  wire [7:0]  reg_wdata,                 // Write data
	output wire [7:0]  reg_rdata,                 // Read data, registered
	input  wire        external_video_clock_pin,  // Pixel clock from source
	input  wire        line_locked_clock,         // Alternate pixel clock
	input  wire        clock_select,              // 1 selects line-locked clock
	input  wire        blank_n,                   // Blanking, active low
	input  wire        external_sync_pin,         // Frame sync
	input  wire        video_byte_valid,          // Byte valid, active high
	input  wire        video_input_enable_n,      // Input enable, active low
	input  wire        field_in,                  // Odd/even field
	input  wire [7:0]  fc_data_in,                // Connector data pins in
	output wire [7:0]  fc_data_out,               // Connector data pins out
	output wire        fc_data_oe_n,              // Low while driving pins
	input  wire [7:0]  gfx_pixel,                 // Graphics data for output
	output wire [16:0] capture_data,              // {field, RGB565}
	output wire        capture_valid,             // Word available
	input  wire        capture_ready              // Consumer takes word
);

	// ==========================================================
	// Scaler step: returns {keep, next accumulator}
	function [7:0] vcf_step;
		input [6:0] acc;
		input [5:0] fld;
		reg   [6:0] sum;
		begin
			sum = acc + (`VCF_STEP_BASE - {1'b0, fld});
			if (sum >= `VCF_ACC_FULL) begin
				vcf_step = {1'b1, sum - `VCF_ACC_FULL};
			end else begin
				vcf_step = {1'b0, sum};
			end
		end
	endfunction

	// ==========================================================
	// Register state
	reg [7:0]       index_reg;
	reg [7:0]       key_reg;
	reg [2:0]       ctrl_reg;
	reg [CNT_W-1:0] h_start_reg;
	reg [CNT_W-1:0] h_end_reg;
	reg [CNT_W-1:0] v_start_reg;
	reg [CNT_W-1:0] v_end_reg;
	reg [5:0]       h_scale_reg;
	reg [5:0]       v_scale_reg;
	reg             overflow_reg;
	reg [7:0]       rdata_reg;
	reg [7:0]       rdata_next;
	wire            unlocked;
	wire            data_wr;
	wire            data_rd;
	wire            video_idx;

	// ==========================================================
	// Pin synchronisers and edge finding
	wire [13:0] pins_s;
	reg  [2:0]  pins_d_reg;
	wire        pclk_s;
	wire        blank_s;
	wire        sync_s;
	wire        valid_s;
	wire        en_n_s;
	wire        field_s;
	wire [7:0]  byte_s;
	wire        pclk_rise;
	wire        blank_rise;
	wire        sync_rise;
	wire        pclk_pin;

	// Clock choice before the synchroniser keeps one sampled clock
	assign pclk_pin = clock_select ? line_locked_clock : external_video_clock_pin;

	vcf_sync #(
		.WIDTH (14)
	) u_sync (
		.clock  (clock),
		.arst_n (arst_n),
		.d_in   ({pclk_pin, blank_n, external_sync_pin, video_byte_valid,
		          video_input_enable_n, field_in, fc_data_in}),
		.q_out  (pins_s)
	);

	assign pclk_s  = pins_s[13];
	assign blank_s = pins_s[12];
	assign sync_s  = pins_s[11];
	assign valid_s = pins_s[10];
	assign en_n_s  = pins_s[9];
	assign field_s = pins_s[8];
	assign byte_s  = pins_s[7:0];

	// Previous synchronised levels for edge detection
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pins_d_reg <= 3'h0;
		end else begin
			pins_d_reg <= {pclk_s, blank_s, sync_s};
		end
	end

	assign pclk_rise  = pclk_s && !pins_d_reg[2];
	assign blank_rise = blank_s && !pins_d_reg[1];
	assign sync_rise  = sync_s && !pins_d_reg[0];

	// ==========================================================
	// Indexed register port
	// key match unlocks
	assign unlocked  = (key_reg == `VCF_KEY_VALUE);
	assign data_wr   = reg_cs && reg_wr && (reg_addr == `VCF_PORT_DATA);
	assign data_rd   = reg_cs && reg_rd && (reg_addr == `VCF_PORT_DATA);
	assign video_idx = (index_reg >= `VCF_IDX_CTRL) && (index_reg <= `VCF_IDX_STATUS);

	// Register writes; the key register is always reachable
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			index_reg   <= `VCF_BYTE_ZERO;
			key_reg     <= `VCF_BYTE_ZERO;
			ctrl_reg    <= 3'h0;
			h_start_reg <= `VCF_CNT_ZERO;
			h_end_reg   <= `VCF_CNT_ZERO;
			v_start_reg <= `VCF_CNT_ZERO;
			v_end_reg   <= `VCF_CNT_ZERO;
			h_scale_reg <= `VCF_SCALE_ZERO;
			v_scale_reg <= `VCF_SCALE_ZERO;
		end else begin
			if (reg_cs && reg_wr && (reg_addr == `VCF_PORT_INDEX)) begin
				index_reg <= reg_wdata;
			end
			if (data_wr && (index_reg == `VCF_IDX_KEY)) begin
				key_reg <= reg_wdata;
			end
			if (data_wr && unlocked) begin
				case (index_reg)
					`VCF_IDX_CTRL:   ctrl_reg          <= reg_wdata[2:0];
					`VCF_IDX_HS_LO:  h_start_reg[7:0]  <= reg_wdata;
					`VCF_IDX_HS_HI:  h_start_reg[11:8] <= reg_wdata[3:0];
					`VCF_IDX_HE_LO:  h_end_reg[7:0]    <= reg_wdata;
					`VCF_IDX_HE_HI:  h_end_reg[11:8]   <= reg_wdata[3:0];
					`VCF_IDX_VS_LO:  v_start_reg[7:0]  <= reg_wdata;
					`VCF_IDX_VS_HI:  v_start_reg[11:8] <= reg_wdata[3:0];
					`VCF_IDX_VE_LO:  v_end_reg[7:0]    <= reg_wdata;
					`VCF_IDX_VE_HI:  v_end_reg[11:8]   <= reg_wdata[3:0];
					`VCF_IDX_HSCALE: h_scale_reg       <= reg_wdata[5:0];
					`VCF_IDX_VSCALE: v_scale_reg       <= reg_wdata[5:0];
					default: begin
					end
				endcase
			end
		end
	end

	// ==========================================================
	// Capture datapath state
	reg [CNT_W-1:0] h_cnt_reg;
	reg [CNT_W-1:0] v_cnt_reg;
	reg             phase_reg;
	reg [7:0]       first_byte_reg;
	reg [15:0]      pixel_reg;
	reg             pixel_stb_reg;
	reg             field_reg;
	reg [6:0]       h_acc_reg;
	reg [6:0]       v_acc_reg;
	reg             line_keep_reg;
	reg [7:0]       fc_out_reg;
	wire            accept_in;
	wire            in_window;
	wire [7:0]      h_step;
	wire [7:0]      v_step;
	wire            push;
	wire            fifo_in_ready;
	wire            drive_out;

	// Status read back: live window and field state
	wire [7:0] status_byte;
	assign status_byte = {4'h0, unlocked, in_window, field_reg, overflow_reg};

	// Read mux; locked or unmapped reads return zero
	always @* begin
		rdata_next = rdata_reg;
		if (data_rd) begin
			rdata_next = `VCF_BYTE_ZERO;
			if (index_reg == `VCF_IDX_KEY) begin
				rdata_next = key_reg;
			end else if (video_idx && unlocked) begin
				case (index_reg)
					`VCF_IDX_CTRL:   rdata_next = {5'h00, ctrl_reg};
					`VCF_IDX_HS_LO:  rdata_next = h_start_reg[7:0];
					`VCF_IDX_HS_HI:  rdata_next = {4'h0, h_start_reg[11:8]};
					`VCF_IDX_HE_LO:  rdata_next = h_end_reg[7:0];
					`VCF_IDX_HE_HI:  rdata_next = {4'h0, h_end_reg[11:8]};
					`VCF_IDX_VS_LO:  rdata_next = v_start_reg[7:0];
					`VCF_IDX_VS_HI:  rdata_next = {4'h0, v_start_reg[11:8]};
					`VCF_IDX_VE_LO:  rdata_next = v_end_reg[7:0];
					`VCF_IDX_VE_HI:  rdata_next = {4'h0, v_end_reg[11:8]};
					`VCF_IDX_HSCALE: rdata_next = {2'h0, h_scale_reg};
					`VCF_IDX_VSCALE: rdata_next = {2'h0, v_scale_reg};
					`VCF_IDX_STATUS: rdata_next = status_byte;
					default:         rdata_next = `VCF_BYTE_ZERO;
				endcase
			end
		end
	end

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rdata_reg <= `VCF_BYTE_ZERO;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;

	// ==========================================================
	// Input gating
	// enable pin low and capture set
	// input also taken in standard mode
	assign accept_in = !en_n_s && ctrl_reg[`VCF_CTRL_CAP_EN];

	assign in_window = (h_cnt_reg >= h_start_reg) && (v_cnt_reg >= v_start_reg) &&
	                   (h_cnt_reg < h_end_reg) && (v_cnt_reg < v_end_reg);

	// ==========================================================
	// Horizontal and vertical counters
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			h_cnt_reg <= `VCF_CNT_ZERO;
			v_cnt_reg <= `VCF_CNT_ZERO;
		end else begin
			// clear on blank rise, else count pixel clocks
			if (blank_rise) begin
				h_cnt_reg <= `VCF_CNT_ZERO;
			end else if (pclk_rise) begin
				h_cnt_reg <= h_cnt_reg + `VCF_CNT_ONE;
			end
			// clear on sync rise, else count lines
			if (sync_rise) begin
				v_cnt_reg <= `VCF_CNT_ZERO;
			end else if (blank_rise) begin
				v_cnt_reg <= v_cnt_reg + `VCF_CNT_ONE;
			end
		end
	end

	// ==========================================================
	// Byte pairing; phase resets each line so a stray byte cannot skew it
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			phase_reg      <= 1'b0;
			first_byte_reg <= `VCF_BYTE_ZERO;
			pixel_reg      <= 16'h0000;
			pixel_stb_reg  <= 1'b0;
			field_reg      <= 1'b0;
		end else begin
			pixel_stb_reg <= 1'b0;
			// field tag kept only in interlaced mode
			if (sync_rise) begin
				field_reg <= ctrl_reg[`VCF_CTRL_INTERLACE] ? field_s : 1'b0;
			end
			if (blank_rise || !accept_in) begin
				phase_reg <= 1'b0;
			end else if (pclk_rise && valid_s) begin
				if (!phase_reg) begin
					first_byte_reg <= byte_s;
					phase_reg      <= 1'b1;
				end else begin
					pixel_reg     <= {first_byte_reg, byte_s};
					pixel_stb_reg <= 1'b1;
					phase_reg     <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// Downscaling by accumulators
	// step is 64 minus field
	assign h_step = vcf_step(h_acc_reg, h_scale_reg);
	assign v_step = vcf_step(v_acc_reg, v_scale_reg);

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			h_acc_reg     <= `VCF_ACC_ZERO;
			v_acc_reg     <= `VCF_ACC_ZERO;
			line_keep_reg <= 1'b1;
		end else begin
			if (sync_rise) begin
				v_acc_reg     <= `VCF_ACC_ZERO;
				line_keep_reg <= 1'b1;
			end else if (blank_rise) begin
				v_acc_reg     <= v_step[6:0];
				line_keep_reg <= v_step[7];
			end
			if (blank_rise) begin
				h_acc_reg <= `VCF_ACC_ZERO;
			end else if (pixel_stb_reg && in_window) begin
				h_acc_reg <= h_step[6:0];
			end
		end
	end

	assign push = pixel_stb_reg && in_window && line_keep_reg && h_step[7];

	// Overflow is sticky; a new drop wins over a software clear
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			overflow_reg <= 1'b0;
		end else if (push && !fifo_in_ready) begin
			overflow_reg <= 1'b1;
		end else if (data_wr && unlocked && (index_reg == `VCF_IDX_STATUS) &&
		             reg_wdata[`VCF_STAT_OVERFLOW]) begin
			overflow_reg <= 1'b0;
		end
	end

	// Buffer absorbs memory stalls; words dropped when full
	vcf_fifo #(
		.WIDTH  (17),
		.DEPTH  (FIFO_DEPTH),
		.ADDR_W (FIFO_AW)
	) u_fifo (
		.clock     (clock),
		.arst_n    (arst_n),
		.in_data   ({field_reg, pixel_reg}),
		.in_valid  (push),
		.in_ready  (fifo_in_ready),
		.out_data  (capture_data),
		.out_valid (capture_valid),
		.out_ready (capture_ready)
	);

	// ==========================================================
	// Standard connector output
	// graphics data driven out
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			fc_out_reg <= `VCF_BYTE_ZERO;
		end else begin
			fc_out_reg <= gfx_pixel;
		end
	end

	// direction from enable pin and mode
	assign drive_out    = ctrl_reg[`VCF_CTRL_STD_MODE] && en_n_s;
	assign fc_data_oe_n = !drive_out;
	assign fc_data_out  = fc_out_reg;

endmodule

//--- hw/vcf_consts.vh
// Constants shared by the video capture front end.
// Assumes inclusion by bare name from the capture design file under hw/.
`ifndef VCF_CONSTS_VH
`define VCF_CONSTS_VH

// ==========================================================
// Indexed register port
`define VCF_PORT_INDEX      1'b0
`define VCF_PORT_DATA       1'b1
`define VCF_IDX_KEY         8'h80
`define VCF_KEY_VALUE       8'h86
`define VCF_IDX_CTRL        8'h90
`define VCF_IDX_HS_LO       8'h91
`define VCF_IDX_HS_HI       8'h92
`define VCF_IDX_HE_LO       8'h93
`define VCF_IDX_HE_HI       8'h94
`define VCF_IDX_VS_LO       8'h95
`define VCF_IDX_VS_HI       8'h96
`define VCF_IDX_VE_LO       8'h97
`define VCF_IDX_VE_HI       8'h98
`define VCF_IDX_HSCALE      8'h99
`define VCF_IDX_VSCALE      8'h9A
`define VCF_IDX_STATUS      8'h9B

// ==========================================================
// Field positions and reset values
`define VCF_CTRL_CAP_EN     0
`define VCF_CTRL_STD_MODE   1
`define VCF_CTRL_INTERLACE  2
`define VCF_STAT_OVERFLOW   0
`define VCF_STAT_FIELD      1
`define VCF_STAT_ACTIVE     2
`define VCF_STAT_UNLOCKED   3
`define VCF_BYTE_ZERO       8'h00
`define VCF_CNT_ZERO        12'h000
`define VCF_CNT_ONE         12'h001
`define VCF_SCALE_ZERO      6'h00

// ==========================================================
// Scaler accumulator
`define VCF_ACC_ZERO        7'h00
`define VCF_ACC_FULL        7'h40
`define VCF_STEP_BASE       7'h40

`endif

//--- hw/vcf_sync.v
// Two-flop synchroniser for a bundle of level signals.
// Assumes each bit is a slow level relative to clock; no word coherence.
`timescale 1ns/1ps

module vcf_sync #(
	parameter WIDTH = 1
) (
	input  wire             clock,   // System clock
	input  wire             arst_n,  // Async reset, active low
	input  wire [WIDTH-1:0] d_in,    // Asynchronous inputs
	output wire [WIDTH-1:0] q_out    // Synchronised outputs
);

	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] sync_reg;

	// ==========================================================
	// Two stages; first stage read by second stage only
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			meta_reg <= {WIDTH{1'b0}};
			sync_reg <= {WIDTH{1'b0}};
		end else begin
			meta_reg <= d_in;
			sync_reg <= meta_reg;
		end
	end

	assign q_out = sync_reg;

endmodule

//--- hw/vcf_fifo.v
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; depth is a power of two.
`timescale 1ns/1ps

module vcf_fifo #(
	parameter WIDTH  = 17,
	parameter DEPTH  = 16,
	parameter ADDR_W = 4
) (
	input  wire             clock,      // System clock
	input  wire             arst_n,     // Async reset, active low
	input  wire [WIDTH-1:0] in_data,    // Write data
	input  wire             in_valid,   // Write request
	output wire             in_ready,   // Not full
	output wire [WIDTH-1:0] out_data,   // Head word
	output wire             out_valid,  // Not empty
	input  wire             out_ready   // Consumer takes head
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [ADDR_W:0]  wptr_reg;
	reg [ADDR_W:0]  rptr_reg;
	wire            full;
	wire            empty;
	wire            push;
	wire            pop;

	// Extra pointer bit tells full from empty
	assign full      = (wptr_reg[ADDR_W] != rptr_reg[ADDR_W]) &&
	                   (wptr_reg[ADDR_W-1:0] == rptr_reg[ADDR_W-1:0]);
	assign empty     = (wptr_reg == rptr_reg);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign push      = in_valid && !full;
	assign pop       = out_ready && !empty;
	assign out_data  = mem[rptr_reg[ADDR_W-1:0]];

	// ==========================================================
	// Storage, no reset needed on data
	always @(posedge clock) begin
		if (push) begin
			mem[wptr_reg[ADDR_W-1:0]] <= in_data;
		end
	end

	// ==========================================================
	// Pointers
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wptr_reg <= {(ADDR_W+1){1'b0}};
			rptr_reg <= {(ADDR_W+1){1'b0}};
		end else begin
			if (push) begin
				wptr_reg <= wptr_reg + 1'b1;
			end
			if (pop) begin
				rptr_reg <= rptr_reg + 1'b1;
			end
		end
	end

endmodule

//--- testbench/vcf_capture_checker.sv
// Concurrent checks on the capture front end ports.
// Assumes binding into vcf_capture; sees its ports only.
`timescale 1ns/1ps

module vcf_capture_chk (
	input logic        clock, // System clock
	input logic        arst_n, // Async reset, active low
	input logic        reg_cs, // Register select
	input logic        reg_addr, // Port select
	input logic        reg_rd, // Read strobe
	input logic [7:0]  reg_rdata, // Read data
	input logic        external_video_clock_pin, // Pixel clock
	input logic        line_locked_clock, // Alternate clock
	input logic        clock_select, // Clock choice
	input logic        blank_n, // Blanking
	input logic        video_byte_valid, // Byte valid
	input logic        video_input_enable_n, // Input enable
	input logic [7:0]  gfx_pixel, // Graphics byte
	input logic [7:0]  fc_data_out, // Pins out
	input logic        fc_data_oe_n, // Pin drive
	input logic [16:0] capture_data, // FIFO head
	input logic        capture_valid, // Word available
	input logic        capture_ready // Consumer pop
);
	default clocking dc @(posedge clock); endclocking
	default disable iff (!arst_n);

	// ==========================================================
	// Helper counters
	reg  [7:0] since_vld_reg;
	reg  [7:0] since_en_reg;
	reg  [3:0] edges_reg;
	reg        pclk_d_reg;
	reg        blank_d_reg;
	wire       pclk_sel = clock_select ? line_locked_clock : external_video_clock_pin;
	wire       rd_hit = reg_cs && reg_rd && reg_addr;

	// Ages saturate so a long idle never wraps into a false pass
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			since_vld_reg <= 8'hFF;
			since_en_reg  <= 8'hFF;
			edges_reg     <= 4'h0;
			pclk_d_reg    <= 1'b0;
			blank_d_reg   <= 1'b0;
		end else begin
			since_vld_reg <= video_byte_valid ? 8'h00 :
				since_vld_reg + {7'h00, ~&since_vld_reg};
			since_en_reg  <= !video_input_enable_n ? 8'h00 :
				since_en_reg + {7'h00, ~&since_en_reg};
			pclk_d_reg    <= pclk_sel;
			blank_d_reg   <= blank_n;
			if (blank_n && !blank_d_reg)
				edges_reg <= 4'h0;
			else if (pclk_sel && !pclk_d_reg && edges_reg != 4'hF)
				edges_reg <= edges_reg + 4'h1;
		end
	end

	// ==========================================================
	// Properties
	property p_rdata_hold;
		$past(arst_n) && !$past(rd_hit) |-> $stable(reg_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
	property p_valid_gate;
		$rose(capture_valid) |-> since_vld_reg < 8'd12;
	endproperty
	a_valid_gate: assert property (p_valid_gate) else $error("word without valid");
	property p_enable_gate;
		$rose(capture_valid) |-> since_en_reg < 8'd12;
	endproperty
	a_enable_gate: assert property (p_enable_gate) else $error("word while disabled");
	property p_two_bytes;
		$rose(capture_valid) |-> edges_reg >= 4'h2;
	endproperty
	a_two_bytes: assert property (p_two_bytes) else $error("pixel before two bytes");
	property p_pop_only;
		$fell(capture_valid) |-> $past(capture_ready);
	endproperty
	a_pop_only: assert property (p_pop_only) else $error("word lost");
	property p_head_hold;
		capture_valid && !capture_ready |=> capture_valid && $stable(capture_data);
	endproperty
	a_head_hold: assert property (p_head_hold) else $error("head changed");
	property p_dir_in;
		(!video_input_enable_n) [*4] |-> fc_data_oe_n;
	endproperty
	a_dir_in: assert property (p_dir_in) else $error("pins driven in input");
	property p_gfx_out;
		$past(arst_n) |-> fc_data_out == $past(gfx_pixel);
	endproperty
	a_gfx_out: assert property (p_gfx_out) else $error("graphics out wrong");

	c_pop: cover property (capture_valid && capture_ready);
	c_drive: cover property (!fc_data_oe_n);
	c_read: cover property (rd_hit);
endmodule

bind vcf_capture vcf_capture_chk u_chk (
	.clock(clock), .arst_n(arst_n), .reg_cs(reg_cs), .reg_addr(reg_addr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.external_video_clock_pin(external_video_clock_pin),
	.line_locked_clock(line_locked_clock), .clock_select(clock_select),
	.blank_n(blank_n), .video_byte_valid(video_byte_valid),
	.video_input_enable_n(video_input_enable_n), .gfx_pixel(gfx_pixel),
	.fc_data_out(fc_data_out), .fc_data_oe_n(fc_data_oe_n),
	.capture_data(capture_data), .capture_valid(capture_valid),
	.capture_ready(capture_ready)
);

//--- testbench/vcf_video_src.sv
// Behavioural video source on the connector side.
// Assumes a go pulse per frame; pixel clock idles low between lines.
`timescale 1ns/1ps

module vcf_video_src (
	input  logic       go, // Start one frame
	input  logic [3:0] n_lines, // Lines per frame
	input  logic       vld_on, // Byte valid during lines
	output logic       pclk, // Pixel clock
	output logic       blank_n, // Blanking, active low
	output logic       sync, // Frame sync
	output logic       bvalid, // Byte valid
	output logic [7:0] data, // Connector byte
	output logic       field, // Field flag
	output logic       done // Frame finished
);
	integer l;
	integer k;
	initial begin
		pclk = 0; blank_n = 0; sync = 0; bvalid = 0; data = 8'h00; field = 1; done = 0;
	end
	// ==========================================================
	// Frame generator; byte value encodes line and byte number
	// two bytes per pixel
	// rate ceiling, one byte per 80 ns
	always @(posedge go) begin
		done = 0;
		sync = 1;
		#200 sync = 0;
		#200;
		for (l = 1; l <= n_lines; l = l + 1) begin
			blank_n = 0;
			#200 blank_n = 1;
			#100;
			for (k = 1; k <= 8; k = k + 1) begin
				data = {l[3:0], k[3:0]};
				bvalid = vld_on;
				#40 pclk = 1;
				#40 pclk = 0;
			end
			// Released bus shows the inverse, not a stale byte
			bvalid = 0;
			data = ~data;
		end
		blank_n = 0;
		#200 done = 1;
	end
endmodule

//--- testbench/tb_video_capture_front_end.sv
// Self-checking bench for the capture front end.
// Assumes vcf_video_src on the connector and the bound checker.
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_video_capture_front_end;
	typedef struct packed {
		logic        csel;
		logic [7:0]  ctrl;
		logic [11:0] hs, he, vs, ve;
		logic [5:0]  hsc, vsc;
		logic [7:0]  n;
		logic [16:0] first;
	} vcf_row_t;
	reg          clock = 0, arst_n = 0, reg_cs = 0, reg_addr = 0, reg_wr = 0, reg_rd = 0;
	reg          csel = 0, en_n = 0, cap_ready = 1, go = 0, vld_on = 1;
	reg  [7:0]   reg_wdata = 8'h00, gfx = 8'h5A, rd_val;
	reg  [3:0]   n_lines = 4'h4;
	reg  [16:0]  first_w;
	wire [7:0]   reg_rdata, fc_in, fc_out;
	wire         pclk, blank_n, sync, bvalid, field, done, oe_n, cap_valid;
	wire [16:0]  cap_data;
	integer      n_mismatch = 0, checked = 0, n_pop = 0, cycles = 0, i;
	vcf_row_t    rows [0:4];

	always #5 clock = ~clock;
	vcf_video_src u_src (.go(go), .n_lines(n_lines), .vld_on(vld_on), .pclk(pclk),
		.blank_n(blank_n), .sync(sync), .bvalid(bvalid), .data(fc_in), .field(field), .done(done));
	vcf_capture dut (.clock(clock), .arst_n(arst_n), .reg_cs(reg_cs), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.external_video_clock_pin(csel ? 1'b0 : pclk), .line_locked_clock(csel ? pclk : 1'b0),
		.clock_select(csel), .blank_n(blank_n), .external_sync_pin(sync),
		.video_byte_valid(bvalid), .video_input_enable_n(en_n), .field_in(field),
		.fc_data_in(fc_in), .fc_data_out(fc_out), .fc_data_oe_n(oe_n), .gfx_pixel(gfx),
		.capture_data(cap_data), .capture_valid(cap_valid), .capture_ready(cap_ready));

	// ==========================================================
	// Consumer pops; hang guard at about five times the run
	always @(posedge clock) begin
		if (cap_valid && cap_ready) begin
			if (n_pop == 0) first_w = cap_data;
			n_pop++;
		end
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			stop_test;
		end
	end

	// ==========================================================
	// Register port and frame tasks
	task wreg(input [7:0] a, input [7:0] d);
		begin
			reg_cs = 1; reg_wr = 1; reg_addr = 0; reg_wdata = a;
			@(negedge clock); reg_addr = 1; reg_wdata = d;
			@(negedge clock); reg_cs = 0; reg_wr = 0;
			@(negedge clock);
		end
	endtask
	task rreg(input [7:0] a, output [7:0] d);
		begin
			reg_cs = 1; reg_wr = 1; reg_addr = 0; reg_wdata = a;
			@(negedge clock); reg_wr = 0; reg_rd = 1; reg_addr = 1;
			@(negedge clock); reg_cs = 0; reg_rd = 0;
			@(negedge clock); d = reg_rdata;
		end
	endtask
	task setup(input vcf_row_t r);
		begin
			wreg(8'h90, r.ctrl);
			wreg(8'h91, r.hs[7:0]); wreg(8'h92, {4'h0, r.hs[11:8]});
			wreg(8'h93, r.he[7:0]); wreg(8'h94, {4'h0, r.he[11:8]});
			wreg(8'h95, r.vs[7:0]); wreg(8'h96, {4'h0, r.vs[11:8]});
			wreg(8'h97, r.ve[7:0]); wreg(8'h98, {4'h0, r.ve[11:8]});
			wreg(8'h99, {2'b00, r.hsc}); wreg(8'h9A, {2'b00, r.vsc});
		end
	endtask
	task frame(input [3:0] n, input v);
		begin
			n_pop = 0; n_lines = n; vld_on = v; go = 1;
			@(negedge clock); go = 0;
			while (done !== 1'b1) @(negedge clock);
			repeat (20) @(negedge clock);
		end
	endtask
	task stop_test;
		begin
			$display("mismatches=%0d checks=%0d", n_mismatch, checked);
			if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
			else $display("STATUS NOT OK");
			$finish;
		end
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		rows[0] = '{1'b0, 8'h01, 12'h000, 12'hFFF, 12'h000, 12'hFFF, 6'h00, 6'h00, 8'd16, 17'h01112};
		rows[1] = '{1'b0, 8'h01, 12'h005, 12'h007, 12'h002, 12'h003, 6'h00, 6'h00, 8'd1, 17'h02526};
		rows[2] = '{1'b0, 8'h01, 12'h000, 12'hFFF, 12'h000, 12'hFFF, 6'd32, 6'd32, 8'd4, 17'h02324};
		rows[3] = '{1'b0, 8'h01, 12'h000, 12'hFFF, 12'h000, 12'hFFF, 6'd48, 6'h00, 8'd4, 17'h01718};
		rows[4] = '{1'b1, 8'h05, 12'h000, 12'hFFF, 12'h000, 12'hFFF, 6'h00, 6'h00, 8'd16, 17'h11112};
		repeat (8) @(negedge clock);
		arst_n = 1;
		@(negedge clock);
		`CHK(reg_rdata, 8'h00)
		`CHK(cap_valid, 1'b0)
		`CHK(oe_n, 1'b1)
		// Locked: writes and reads refused, no capture
		wreg(8'h90, 8'h01);
		frame(4'h1, 1'b1);
		`CHK(n_pop, 0)
		rreg(8'h9B, rd_val); `CHK(rd_val, 8'h00)
		rreg(8'h7F, rd_val); `CHK(rd_val, 8'h00)
		wreg(8'h80, 8'h86);
		rreg(8'h80, rd_val); `CHK(rd_val, 8'h86)
		rreg(8'h9B, rd_val); `CHK(rd_val[3], 1'b1)
		rreg(8'h90, rd_val); `CHK(rd_val, 8'h00)
		// Window, scaling, field and clock choice table
		for (i = 0; i < 5; i = i + 1) begin
			csel = rows[i].csel;
			setup(rows[i]);
			frame(4'h4, 1'b1);
			`CHK(n_pop, rows[i].n)
			`CHK(first_w, rows[i].first)
		end
		// Bytes without valid, then with enable pin high
		csel = 0;
		wreg(8'h90, 8'h01);
		frame(4'h4, 1'b0);
		`CHK(n_pop, 0)
		en_n = 1;
		frame(4'h4, 1'b1);
		`CHK(n_pop, 0)
		// Standard mode: drive graphics out, then still accept video
		wreg(8'h90, 8'h03);
		gfx = 8'hC3;
		repeat (4) @(negedge clock);
		`CHK(oe_n, 1'b0)
		`CHK(fc_out, 8'hC3)
		en_n = 0;
		repeat (4) @(negedge clock);
		`CHK(oe_n, 1'b1)
		frame(4'h1, 1'b1);
		`CHK(n_pop, 4)
		// Consumer stalls: fill past depth, drain, clear overflow
		cap_ready = 0;
		frame(4'h5, 1'b1);
		`CHK(cap_valid, 1'b1)
		cap_ready = 1;
		repeat (20) @(negedge clock);
		`CHK(n_pop, 16)
		`CHK(cap_valid, 1'b0)
		rreg(8'h9B, rd_val); `CHK(rd_val[0], 1'b1)
		wreg(8'h9B, 8'h01);
		rreg(8'h9B, rd_val); `CHK(rd_val[0], 1'b0)
		// Any other key value locks again
		wreg(8'h80, 8'h00);
		rreg(8'h90, rd_val); `CHK(rd_val, 8'h00)
		stop_test;
	end
endmodule
